/* File: bod_alu.v */
// Combinational operation unit for the byte-oriented instruction group.
`timescale 1ns/10ps
`include "bod_defines.vh"
module bod_alu (
  input  wire [6:0]  opc_i,
  input  wire [7:0]  w_i,
  input  wire [7:0]  f_i,
  input  wire        c_i,
  output reg  [7:0]  res_o,
  output reg  [4:0]  flg_o,
  output reg  [4:0]  mask_o,
  output reg         wr_o,
  output reg         tof_o,
  output reg         skip_o,
  output reg         mul_o,
  output wire [15:0] prod_o
);

  reg  [7:0] a;
  reg  [7:0] b;
  reg        ci;
  reg        use_add;
  reg        rc;
  reg        skz;
  reg        sknz;
  reg  [8:0] sum;
  reg  [4:0] hsum;

  assign prod_o = {8'h00, w_i} * {8'h00, f_i};

  always @* begin
    a       = w_i;
    b       = f_i;
    ci      = 1'b0;
    use_add = 1'b0;
    rc      = c_i;
    skz     = 1'b0;
    sknz    = 1'b0;
    res_o   = 8'h00;
    mask_o  = 5'h00;
    wr_o    = 1'b0;
    tof_o   = opc_i[0];
    skip_o  = 1'b0;
    mul_o   = 1'b0;
    casez (opc_i)
      `BOD_OP_MUL:    mul_o = 1'b1;
      `BOD_OP_DECF:   begin a = f_i; b = 8'hFE; ci = 1'b1; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_IOR:    begin res_o = w_i | f_i; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_AND:    begin res_o = w_i & f_i; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_XOR:    begin res_o = w_i ^ f_i; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_COM:    begin res_o = ~f_i; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_ADDC:   begin ci = c_i; use_add = 1'b1; mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_ADD:    begin use_add = 1'b1; mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_INCF:   begin a = f_i; b = 8'h00; ci = 1'b1; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_DECSZ:  begin res_o = f_i - 8'h01; skz = 1'b1; wr_o = 1'b1; end
      `BOD_OP_RRC:    begin res_o = {c_i, f_i[7:1]}; rc = f_i[0];
                        mask_o = `BOD_MASK_CZN; wr_o = 1'b1; end
      `BOD_OP_RLC:    begin res_o = {f_i[6:0], c_i}; rc = f_i[7];
                        mask_o = `BOD_MASK_CZN; wr_o = 1'b1; end
      `BOD_OP_SWAP:   begin res_o = {f_i[3:0], f_i[7:4]}; wr_o = 1'b1; end
      `BOD_OP_INCSZ:  begin res_o = f_i + 8'h01; skz = 1'b1; wr_o = 1'b1; end
      `BOD_OP_RRN:    begin res_o = {f_i[0], f_i[7:1]}; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_RLN:    begin res_o = {f_i[6:0], f_i[7]}; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_INCSNZ: begin res_o = f_i + 8'h01; sknz = 1'b1; wr_o = 1'b1; end
      `BOD_OP_DECSNZ: begin res_o = f_i - 8'h01; sknz = 1'b1; wr_o = 1'b1; end
      `BOD_OP_MOVF:   begin res_o = f_i; mask_o = `BOD_MASK_ZN; wr_o = 1'b1; end
      `BOD_OP_SUBFB:  begin b = ~f_i; ci = c_i; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_SUBWB:  begin a = f_i; b = ~w_i; ci = c_i; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_SUB:    begin a = f_i; b = ~w_i; ci = 1'b1; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; end
      `BOD_OP_CPLT:   skip_o = (f_i < w_i);
      `BOD_OP_CPEQ:   skip_o = (f_i == w_i);
      `BOD_OP_CPGT:   skip_o = (f_i > w_i);
      `BOD_OP_TSTZ:   skip_o = (f_i == 8'h00);
      `BOD_OP_SET:    begin res_o = 8'hFF; wr_o = 1'b1; tof_o = 1'b1; end
      `BOD_OP_CLR:    begin res_o = 8'h00; mask_o = `BOD_MASK_Z; wr_o = 1'b1; tof_o = 1'b1; end
      `BOD_OP_NEG:    begin a = 8'h00; b = ~f_i; ci = 1'b1; use_add = 1'b1;
                        mask_o = `BOD_MASK_ALL; wr_o = 1'b1; tof_o = 1'b1; end
      `BOD_OP_MOVWF:  begin res_o = w_i; wr_o = 1'b1; tof_o = 1'b1; end
      default:        wr_o = 1'b0;
    endcase
    sum  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    hsum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    if (use_add) begin
      res_o = sum[7:0];
      rc    = sum[8];
    end
    flg_o[`BOD_FLG_C]  = rc;
    flg_o[`BOD_FLG_DC] = hsum[4];
    flg_o[`BOD_FLG_Z]  = (res_o == 8'h00);
    flg_o[`BOD_FLG_OV] = (a[7] == b[7]) && (res_o[7] != a[7]);
    flg_o[`BOD_FLG_N]  = res_o[7];
    if ((skz && res_o == 8'h00) || (sknz && res_o != 8'h00)) begin
      skip_o = 1'b1;
    end
  end

endmodule

/* File: bod_core.v */
// Byte-operation decode and execute core with a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "bod_defines.vh"
module bod_core (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [11:0] imem_addr_o,
  input  wire [15:0] imem_data_i,
  input  wire [7:0]  port_pins_i,
  output reg  [7:0]  port_latch_o,
  output reg         t0_psc_clr_o,
  output reg  [1:0]  q_phase_o
);

  // ****************************************
  // State
  // ****************************************
  reg  [7:0]  ram_q [0:`BOD_RAM_WORDS-1];
  reg  [2:0]  ctrl_ff;
  reg  [15:0] ir_ff;
  reg  [11:0] fadr_ff;
  reg  [7:0]  opnd_ff;
  reg  [7:0]  res_ff;
  reg  [4:0]  flgn_ff;
  reg  [4:0]  fmask_ff;
  reg         wr_ff;
  reg         tof_ff;
  reg         skip_ff;
  reg         mul_ff;
  reg  [15:0] mprod_ff;
  reg         squash_ff;
  reg         mov_pend_ff;
  reg  [7:0]  mov_data_ff;
  reg  [7:0]  w_ff;
  reg  [4:0]  st_ff;
  reg  [3:0]  bsr_ff;
  reg  [7:0]  idx_ff;
  reg  [7:0]  t0_ff;
  reg  [15:0] prod_ff;
  reg  [11:0] faddr_ff;

  wire [7:0]  alu_res;
  wire [4:0]  alu_flg;
  wire [4:0]  alu_mask;
  wire        alu_wr;
  wire        alu_tof;
  wire        alu_skip;
  wire        alu_mul;
  wire [15:0] alu_prod;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Effective file address from f, a, extended mode and bank
  function [11:0] ea_calc;
    input [7:0] f;
    input       a;
    input       ext;
    input [3:0] bank_select_register;
    input [7:0] idx;
    begin
      if (a) begin
        ea_calc = {bank_select_register, f};
      end else if (ext && f <= `BOD_IDX_LIMIT) begin
        ea_calc = {4'h0, idx} + {4'h0, f};
      end else if (f < `BOD_ACC_SPLIT) begin
        ea_calc = {4'h0, f};
      end else begin
        ea_calc = {4'hF, f};
      end
    end
  endfunction

  // Special registers from F80 up; the port reads its pins
  function [7:0] file_read;
    input [11:0] fa;
    begin
      case (fa)
        `BOD_FA_PORT:   file_read = port_pins_i;
        `BOD_FA_TIMER_ZERO_COUNT:   file_read = t0_ff;
        `BOD_FA_WORKING_REGISTER:   file_read = w_ff;
        `BOD_FA_STATUS: file_read = {3'h0, st_ff};
        `BOD_FA_BSR:    file_read = {4'h0, bsr_ff};
        `BOD_FA_PRODL:  file_read = prod_ff[7:0];
        `BOD_FA_PRODH:  file_read = prod_ff[15:8];
        `BOD_FA_INDEX:  file_read = idx_ff;
        default:        file_read = (fa[11:8] == 4'h0) ? ram_q[fa[7:0]] : 8'h00;
      endcase
    end
  endfunction

  // Byte-lane merge for the 16-bit bus registers
  function [15:0] bmerge;
    input [15:0] old;
    input [15:0] d;
    input [1:0]  sel;
    begin
      bmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************
  // Sequencing terms
  // ****************************************
  // Run clear halts only at a cycle boundary
  wire        advance  = ctrl_ff[`BOD_CTRL_RUN] || (q_phase_o != `BOD_Q1);
  wire        halted   = !ctrl_ff[`BOD_CTRL_RUN] && (q_phase_o == `BOD_Q1);
  wire        at_q4    = advance && (q_phase_o == `BOD_Q4);
  // Squashed words and a move second word commit no ALU result or flags
  wire        live     = !squash_ff && !mov_pend_ff;
  wire        bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire        hbus_wr  = bus_wr && halted;
  wire        core_fwr = at_q4 && ((live && wr_ff && tof_ff) || mov_pend_ff);
  wire        bus_fwr  = hbus_wr && (wb_adr_i == `BOD_WB_FDATA) && wb_sel_i[0];
  wire        w_commit = at_q4 && live && wr_ff && !tof_ff;
  wire        f_commit = at_q4 && live;
  reg  [11:0] wr_addr;
  reg  [7:0]  wr_data;
  reg         wr_en;

  // Core and bus file writes never meet in one cycle
  always @* begin
    wr_en   = core_fwr || bus_fwr;
    wr_addr = faddr_ff;
    wr_data = wb_dat_i[7:0];
    if (core_fwr) begin
      wr_addr = mov_pend_ff ? ir_ff[11:0] : fadr_ff;
      wr_data = mov_pend_ff ? mov_data_ff : res_ff;
    end
  end

  bod_alu u_alu (
    .opc_i  (ir_ff[15:9]),
    .w_i    (w_ff),
    .f_i    (opnd_ff),
    .c_i    (st_ff[`BOD_FLG_C]),
    .res_o  (alu_res),
    .flg_o  (alu_flg),
    .mask_o (alu_mask),
    .wr_o   (alu_wr),
    .tof_o  (alu_tof),
    .skip_o (alu_skip),
    .mul_o  (alu_mul),
    .prod_o (alu_prod)
  );

  // ****************************************
  // Bus byte-lane merges
  // ****************************************
  wire [15:0] pc_merge = bmerge({4'h0, imem_addr_o}, wb_dat_i[15:0], wb_sel_i[1:0]);
  wire [15:0] fa_merge = bmerge({4'h0, faddr_ff}, wb_dat_i[15:0], wb_sel_i[1:0]);

  // ****************************************
  // Four-phase instruction sequencer
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      q_phase_o   <= `BOD_Q1;
      imem_addr_o <= `BOD_PC_RST;
      ir_ff       <= 16'hFFFF;
      fadr_ff     <= 12'h000;
      opnd_ff     <= 8'h00;
      res_ff      <= 8'h00;
      flgn_ff     <= 5'h00;
      fmask_ff    <= 5'h00;
      wr_ff       <= 1'b0;
      tof_ff      <= 1'b0;
      skip_ff     <= 1'b0;
      mul_ff      <= 1'b0;
      mprod_ff    <= 16'h0000;
      squash_ff   <= 1'b0;
      mov_pend_ff <= 1'b0;
      mov_data_ff <= 8'h00;
    end else begin
      if (advance) begin
        q_phase_o <= q_phase_o + 2'h1;
      end
      if (hbus_wr && wb_adr_i == `BOD_WB_PC) begin
        imem_addr_o <= pc_merge[11:0];
      end
      if (advance) begin
        case (q_phase_o)
          `BOD_Q1: begin
            ir_ff <= imem_data_i;
          end
          `BOD_Q2: begin
            if (ir_ff[15:12] == `BOD_PFX_MOVE1) begin
              fadr_ff <= ir_ff[11:0];
              opnd_ff <= file_read(ir_ff[11:0]);
            end else begin
              fadr_ff <= ea_calc(ir_ff[7:0], ir_ff[8], ctrl_ff[`BOD_CTRL_EXT],
                                 bsr_ff, idx_ff);
              opnd_ff <= file_read(ea_calc(ir_ff[7:0], ir_ff[8],
                                   ctrl_ff[`BOD_CTRL_EXT], bsr_ff, idx_ff));
            end
          end
          `BOD_Q3: begin
            res_ff   <= alu_res;
            flgn_ff  <= alu_flg;
            fmask_ff <= alu_mask;
            wr_ff    <= alu_wr;
            tof_ff   <= alu_tof;
            skip_ff  <= alu_skip;
            mul_ff   <= alu_mul;
            mprod_ff <= alu_prod;
          end
          `BOD_Q4: begin
            imem_addr_o <= imem_addr_o + 12'h001;
            // A skipped move first word squashes its second word too
            if (squash_ff) begin
              squash_ff <= (ir_ff[15:12] == `BOD_PFX_MOVE1);
            end else if (mov_pend_ff) begin
              mov_pend_ff <= 1'b0;
            end else if (ir_ff[15:12] == `BOD_PFX_MOVE1) begin
              mov_pend_ff <= 1'b1;
              mov_data_ff <= opnd_ff;
            end else begin
              squash_ff <= skip_ff;
            end
          end
          default: begin
            ir_ff <= ir_ff;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Core registers and file side effects
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      w_ff         <= 8'h00;
      st_ff        <= 5'h00;
      bsr_ff       <= 4'h0;
      idx_ff       <= 8'h00;
      t0_ff        <= 8'h00;
      prod_ff      <= 16'h0000;
      port_latch_o <= 8'h00;
      t0_psc_clr_o <= 1'b0;
    end else begin
      // Instruction writes only; bus writes leave the prescaler alone
      t0_psc_clr_o <= core_fwr && (wr_addr == `BOD_FA_TIMER_ZERO_COUNT)
                      && ctrl_ff[`BOD_CTRL_PSA];
      if (wr_en && wr_addr == `BOD_FA_PORT) begin
        port_latch_o <= wr_data;
      end
      if (wr_en && wr_addr == `BOD_FA_TIMER_ZERO_COUNT) begin
        t0_ff <= wr_data;
      end
      if (wr_en && wr_addr == `BOD_FA_INDEX) begin
        idx_ff <= wr_data;
      end
      // Explicit file write beats the result commit
      if (wr_en && wr_addr == `BOD_FA_WORKING_REGISTER) begin
        w_ff <= wr_data;
      end else if (w_commit) begin
        w_ff <= res_ff;
      end else if (hbus_wr && wb_adr_i == `BOD_WB_WORKING_REGISTER && wb_sel_i[0]) begin
        w_ff <= wb_dat_i[7:0];
      end
      if (wr_en && wr_addr == `BOD_FA_STATUS) begin
        st_ff <= wr_data[4:0];
      end else if (f_commit) begin
        st_ff <= (st_ff & ~fmask_ff) | (flgn_ff & fmask_ff);
      end else if (hbus_wr && wb_adr_i == `BOD_WB_STATUS && wb_sel_i[0]) begin
        st_ff <= wb_dat_i[4:0];
      end
      if (wr_en && wr_addr == `BOD_FA_BSR) begin
        bsr_ff <= wr_data[3:0];
      end else if (hbus_wr && wb_adr_i == `BOD_WB_BSR && wb_sel_i[0]) begin
        bsr_ff <= wb_dat_i[3:0];
      end
      if (f_commit && mul_ff) begin
        prod_ff <= mprod_ff;
      end else if (wr_en && wr_addr == `BOD_FA_PRODL) begin
        prod_ff <= {prod_ff[15:8], wr_data};
      end else if (wr_en && wr_addr == `BOD_FA_PRODH) begin
        prod_ff <= {wr_data, prod_ff[7:0]};
      end
    end
  end

  // ****************************************
  // Data memory
  // ****************************************
  // Low page only; special registers sit at F80 and up
  always @(posedge clk_i) begin
    if (wr_en && wr_addr[11:8] == 4'h0) begin
      ram_q[wr_addr[7:0]] <= wr_data;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  reg [31:0] rd_val;

  always @* begin
    case (wb_adr_i)
      `BOD_WB_CTRL:   rd_val = {29'h000_0000, ctrl_ff};
      `BOD_WB_WORKING_REGISTER:   rd_val = {24'h00_0000, w_ff};
      `BOD_WB_STATUS: rd_val = {27'h00_0000, st_ff};
      `BOD_WB_BSR:    rd_val = {28'h000_0000, bsr_ff};
      `BOD_WB_PC:     rd_val = {20'h0_0000, imem_addr_o};
      `BOD_WB_PROD:   rd_val = {16'h0000, prod_ff};
      `BOD_WB_FADDR:  rd_val = {20'h0_0000, faddr_ff};
      `BOD_WB_FDATA:  rd_val = {24'h00_0000, file_read(faddr_ff)};
      `BOD_WB_CORE:   rd_val = {28'h000_0000, mov_pend_ff, squash_ff, q_phase_o};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_ff  <= `BOD_CTRL_RST;
      faddr_ff <= 12'h000;
    end else begin
      // One wait state; ack drops the cycle after it is given
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= rd_val;
      end
      if (bus_wr && wb_adr_i == `BOD_WB_CTRL && wb_sel_i[0]) begin
        ctrl_ff <= wb_dat_i[2:0];
      end
      if (bus_wr && wb_adr_i == `BOD_WB_FADDR) begin
        faddr_ff <= fa_merge[11:0];
      end
    end
  end

endmodule

/* File: bod_core_props.sv */
// Concurrent checks on the ports of the byte-operation core
`timescale 1ns/10ps
module bod_core_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [11:0] imem_addr_o,
  input wire logic [15:0] imem_data_i,
  input wire logic [7:0]  port_pins_i,
  input wire logic [7:0]  port_latch_o,
  input wire logic        t0_psc_clr_o,
  input wire logic [1:0]  q_phase_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_prompt: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack while idle");
  a_phase_step: assert property ((q_phase_o != 2'h0) |=> q_phase_o == $past(q_phase_o) + 2'h1)
    else $error("phase did not advance");
  a_pc_moment: assert property (!$stable(imem_addr_o) |-> $past(q_phase_o) == 2'h3 || $past(wb_ack_o))
    else $error("fetch address moved outside phase four");
  a_latch_moment: assert property (!$stable(port_latch_o) |-> $past(q_phase_o) == 2'h3 || $past(wb_ack_o))
    else $error("port latch moved outside phase four");
  a_psc_pulse: assert property (t0_psc_clr_o |=> !t0_psc_clr_o)
    else $error("prescaler clear longer than one cycle");
  a_psc_moment: assert property (t0_psc_clr_o |-> q_phase_o == 2'h0 || q_phase_o == 2'h1)
    else $error("prescaler clear at wrong phase");
  c_write: cover property (wb_ack_o && $past(wb_we_i));
  c_psc: cover property (t0_psc_clr_o);
  c_q4: cover property (q_phase_o == 2'h3);
endmodule
bind bod_core bod_core_props bod_core_props_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .imem_addr_o,
  .imem_data_i, .port_pins_i, .port_latch_o, .t0_psc_clr_o, .q_phase_o);

/* File: bod_defines.vh */
// Constants for the byte-operation decoder core.
`ifndef BOD_DEFINES_VH
`define BOD_DEFINES_VH

// ****************************************
// Bus register byte offsets
// ****************************************
`define BOD_WB_CTRL   8'h00
`define BOD_WB_WORKING_REGISTER   8'h04
`define BOD_WB_STATUS 8'h08
`define BOD_WB_BSR    8'h0C
`define BOD_WB_PC     8'h10
`define BOD_WB_PROD   8'h14
`define BOD_WB_FADDR  8'h18
`define BOD_WB_FDATA  8'h1C
`define BOD_WB_CORE   8'h20

// ****************************************
// Field positions and reset values
// ****************************************
`define BOD_CTRL_RUN  0
`define BOD_CTRL_EXT  1
`define BOD_CTRL_PSA  2
`define BOD_CTRL_RST  3'h0
`define BOD_FLG_C     0
`define BOD_FLG_DC    1
`define BOD_FLG_Z     2
`define BOD_FLG_OV    3
`define BOD_FLG_N     4
`define BOD_MASK_ALL  5'h1F
`define BOD_MASK_ZN   5'h14
`define BOD_MASK_CZN  5'h15
`define BOD_MASK_Z    5'h04
`define BOD_PC_RST    12'h000

// ****************************************
// File address map
// ****************************************
`define BOD_FA_PORT   12'hF80
`define BOD_FA_TIMER_ZERO_COUNT   12'hF81
`define BOD_FA_WORKING_REGISTER   12'hF82
`define BOD_FA_STATUS 12'hF83
`define BOD_FA_BSR    12'hF84
`define BOD_FA_PRODL  12'hF85
`define BOD_FA_PRODH  12'hF86
`define BOD_FA_INDEX  12'hF87
`define BOD_ACC_SPLIT 8'h80
`define BOD_IDX_LIMIT 8'h5F
`define BOD_RAM_WORDS 256

// ****************************************
// Instruction cycle phases
// ****************************************
`define BOD_Q1 2'h0
`define BOD_Q2 2'h1
`define BOD_Q3 2'h2
`define BOD_Q4 2'h3

// ****************************************
// Opcodes, upper seven bits of the word; move prefixes, upper four bits
// ****************************************
`define BOD_PFX_MOVE1 4'hC
`define BOD_PFX_MOVE2 4'hF
`define BOD_OP_MUL    7'b0000_001
`define BOD_OP_DECF   7'b0000_01?
`define BOD_OP_IOR    7'b0001_00?
`define BOD_OP_AND    7'b0001_01?
`define BOD_OP_XOR    7'b0001_10?
`define BOD_OP_COM    7'b0001_11?
`define BOD_OP_ADDC   7'b0010_00?
`define BOD_OP_ADD    7'b0010_01?
`define BOD_OP_INCF   7'b0010_10?
`define BOD_OP_DECSZ  7'b0010_11?
`define BOD_OP_RRC    7'b0011_00?
`define BOD_OP_RLC    7'b0011_01?
`define BOD_OP_SWAP   7'b0011_10?
`define BOD_OP_INCSZ  7'b0011_11?
`define BOD_OP_RRN    7'b0100_00?
`define BOD_OP_RLN    7'b0100_01?
`define BOD_OP_INCSNZ 7'b0100_10?
`define BOD_OP_DECSNZ 7'b0100_11?
`define BOD_OP_MOVF   7'b0101_00?
`define BOD_OP_SUBFB  7'b0101_01?
`define BOD_OP_SUBWB  7'b0101_10?
`define BOD_OP_SUB    7'b0101_11?
`define BOD_OP_CPLT   7'b0110_000
`define BOD_OP_CPEQ   7'b0110_001
`define BOD_OP_CPGT   7'b0110_010
`define BOD_OP_TSTZ   7'b0110_011
`define BOD_OP_SET    7'b0110_100
`define BOD_OP_CLR    7'b0110_101
`define BOD_OP_NEG    7'b0110_110
`define BOD_OP_MOVWF  7'b0110_111

`endif

/* File: bod_pmem.sv */
// Program memory model feeding instruction words
`timescale 1ns/10ps
module bod_pmem (
  input  wire logic [11:0] addr_i,
  output wire logic [15:0] data_o
);
  logic [15:0] mem [0:3];
  // Unloaded words read as a lone second word, a no-op
  assign data_o = (addr_i < 12'h004) ? mem[addr_i[1:0]] : 16'hFFFF;
endmodule

/* File: tb.sv */
// Self-checking bench for the byte-operation core
`timescale 1ns/10ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, t0_psc_clr_o;
  logic [11:0] imem_addr_o;
  logic [15:0] imem_data_i;
  logic [7:0]  port_pins_i = 8'hA5;
  logic [7:0]  port_latch_o, a;
  logic [1:0]  q_phase_o;
  int          err_count = 0, n_checks = 0, psc_cnt = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (t0_psc_clr_o === 1'b1) psc_cnt <= psc_cnt + 1;
  bod_core bod_core_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .imem_addr_o, .imem_data_i,
    .port_pins_i, .port_latch_o, .t0_psc_clr_o, .q_phase_o);
  bod_pmem bod_pmem_inst (.addr_i(imem_addr_o), .data_o(imem_data_i));
  task chk(input [31:0] s, input [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input w, input [7:0] ad, input [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= ad;
    wb_dat_i <= d; wb_sel_i <= 4'h3;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask
  task wr(input [7:0] ad, input [31:0] d); bus(1'b1, ad, d); endtask
  task rd(input [7:0] ad, input [31:0] e); bus(1'b0, ad, 32'h0000_0000); chk(q, e); endtask
  task fw(input [11:0] fa, input [7:0] d); wr(8'h18, {20'h0_0000, fa}); wr(8'h1C, {24'h00_0000, d}); endtask
  task fr(input [11:0] fa, input [7:0] e); wr(8'h18, {20'h0_0000, fa}); rd(8'h1C, {24'h00_0000, e}); endtask
  // Load four words, run from zero until the fifth fetch, then halt
  task exec(input [15:0] i0, i1, i2, i3, input [2:0] ctl);
    bod_pmem_inst.mem[0] = i0; bod_pmem_inst.mem[1] = i1;
    bod_pmem_inst.mem[2] = i2; bod_pmem_inst.mem[3] = i3;
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, {29'h000_0000, ctl | 3'h1});
    while (imem_addr_o !== 12'h004) @(posedge clk_i);
    wr(8'h00, 32'h0000_0000);
    while (q_phase_o !== 2'h0) @(posedge clk_i);
  endtask
  // One byte op on file 05, followed by a set of file 20 that a skip must squash
  task op(input [6:0] oc, input [7:0] w, f, input [4:0] si, input [7:0] ew, ef,
          input [4:0] so, input sk);
    wr(8'h04, {24'h00_0000, w}); wr(8'h08, {27'h00_0000, si});
    fw(12'h005, f); fw(12'h020, 8'h00);
    exec({oc, 1'b0, 8'h05}, 16'h6820, 16'hFFFF, 16'hFFFF, 3'h0);
    rd(8'h04, {24'h00_0000, ew}); rd(8'h08, {27'h00_0000, so});
    fr(12'h005, ef); fr(12'h020, sk ? 8'h00 : 8'hFF);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'h24, 32'hFFFF_FFFF);
    for (a = 8'h00; a < 8'h28; a = a + 8'h04) if (a != 8'h1C) rd(a, 32'h0000_0000);
    $display("test reset done");
    op(7'b0010000, 8'h0F, 8'h01, 5'h01, 8'h11, 8'h01, 5'h02, 1'b0);
    op(7'b0001001, 8'h80, 8'h00, 5'h0F, 8'h80, 8'h80, 5'h1B, 1'b0);
    op(7'b0001100, 8'h5A, 8'h5A, 5'h10, 8'h00, 8'h5A, 5'h04, 1'b0);
    op(7'b0011011, 8'h00, 8'h80, 5'h0A, 8'h00, 8'h00, 5'h0F, 1'b0);
    op(7'b0011000, 8'h00, 8'h01, 5'h01, 8'h80, 8'h01, 5'h11, 1'b0);
    op(7'b0100001, 8'h00, 8'h01, 5'h05, 8'h00, 8'h80, 5'h11, 1'b0);
    op(7'b0101010, 8'h10, 8'h01, 5'h01, 8'h0F, 8'h01, 5'h01, 1'b0);
    op(7'b0101101, 8'h01, 8'h00, 5'h00, 8'h01, 8'hFE, 5'h10, 1'b0);
    op(7'b0010111, 8'h00, 8'h01, 5'h1F, 8'h00, 8'h00, 5'h1F, 1'b1);
    op(7'b0100110, 8'h07, 8'h01, 5'h00, 8'h00, 8'h01, 5'h00, 1'b0);
    op(7'b0011111, 8'h00, 8'hFF, 5'h00, 8'h00, 8'h00, 5'h00, 1'b1);
    op(7'b0100100, 8'h00, 8'h10, 5'h00, 8'h11, 8'h10, 5'h00, 1'b1);
    op(7'b0110001, 8'h33, 8'h33, 5'h00, 8'h33, 8'h33, 5'h00, 1'b1);
    op(7'b0110010, 8'h33, 8'h34, 5'h00, 8'h33, 8'h34, 5'h00, 1'b1);
    op(7'b0110000, 8'h7F, 8'h80, 5'h00, 8'h7F, 8'h80, 5'h00, 1'b0);
    op(7'b0000001, 8'h10, 8'h10, 5'h1F, 8'h10, 8'h10, 5'h1F, 1'b0);
    rd(8'h14, 32'h0000_0100);
    $display("test byte ops done");
    wr(8'h04, 32'h0000_0000);
    exec(16'h1280, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h0);
    chk(port_latch_o, 8'hA5);
    exec(16'h1281, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h4);
    chk(psc_cnt, 1);
    exec(16'h1081, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h4);
    chk(psc_cnt, 1);
    exec(16'h1281, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h0);
    chk(psc_cnt, 1);
    wr(8'h04, 32'h0000_003C); wr(8'h0C, 32'h0000_0000); fw(12'h085, 8'h00);
    exec(16'h1385, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h0);
    fr(12'h085, 8'h3C);
    fw(12'hF87, 8'h10); fw(12'h06F, 8'h00);
    exec(16'h125F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3'h2);
    fr(12'h06F, 8'h3C);
    $display("test addressing done");
    fw(12'h005, 8'h77); fw(12'h006, 8'h00); fw(12'h020, 8'h00);
    exec(16'hC005, 16'hF006, 16'h6820, 16'hFFFF, 3'h0);
    fr(12'h006, 8'h77);
    fr(12'h020, 8'hFF);
    wr(8'h04, 32'h0000_0077); fw(12'h007, 8'h00); fw(12'h020, 8'h00);
    exec(16'h6205, 16'hC005, 16'hF007, 16'h6820, 3'h0);
    fr(12'h007, 8'h00);
    fr(12'h020, 8'hFF);
    $display("test two-word done");
    finish_test;
  end
endmodule
